// ==== logic/plt_top.sv ====
// Top of the pulse limit and trigger controller with its AHB-Lite slave.
// Assumes one 125 MHz clock; limit, trigger and home pins are asynchronous.
`timescale 1ns/100ps
// Operation
// [RULE_01] Refuse start when either limit active.
// [RULE_02] Stop on limit matching travel direction.
// [RULE_03] Selectable limit polarity, default unpowered active.
// [RULE_04] Out of range parameter flags value error.
// [RULE_05] Speed to 4000000 pps, time 32767 ms.
// [RULE_06] Software sets target above startup speed.
// [RULE_07] Active trigger at start counts immediately.
// [RULE_08] Trigger during acceleration counts at once.
// [RULE_09] Without trigger pulses continue indefinitely.
// [RULE_10] Counting begins within 15 us, constant; code counts from the next rising pulse edge.
// [RULE_11] Each axis trigger and counter independent.
// [RULE_12] Soft trigger flag toggle replaces pin.
// [RULE_13] Monitor enable reports timing input state.
// [RULE_14] Software avoids overwriting shared parameters.
// [RULE_15] Codes 0050/0054 select minus/plus home.
// [RULE_16] Codes 00D0/00D4 same, limit inverted.
// [RULE_17] Home from Z phase or switch.
// [RULE_18] Start ignored while busy.
// [RULE_19] Done held until next operation starts.
// [RULE_20] Errors latch readable, busy stays low.
module plt_top
    import plt_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic timing_pin,
    input wire logic lim_plus_pin,
    input wire logic lim_minus_pin,
    input wire logic home_z_pin,
    input wire logic home_sw_pin,
    output logic pulse_out,
    output logic dir_out,
    output logic home_in
);
    // Two-flop synchronisers for the five asynchronous pins.
    logic [4:0] pin_s1_r;
    logic [4:0] pin_s2_r;
    // Registered address phase.
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    // Software-visible registers.
    plt_param_s prm_r;
    logic start_r;
    logic soft_trig_r;
    logic mon_en_r;
    logic start_pulse;
    logic err_clr_pulse;
    plt_stat_s stat;
    logic busy;
    logic done;
    logic [1:0] err;
    logic addr_ok;

    // Bus never waits and always answers OKAY.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Synchronise pins before any logic looks at them.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else begin
            pin_s1_r <= {home_sw_pin, home_z_pin, lim_minus_pin, lim_plus_pin, timing_pin};
            pin_s2_r <= pin_s1_r;
        end
    end

    // Capture a write address phase for use in the data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
        end else if (hready) begin
            wr_pend_r <= hsel && htrans[1] && hwrite;
            wr_addr_r <= haddr;
        end
    end

    // Parameter registers; all modes share this one area.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prm_r <= '0;
            prm_r.div <= DIV_RST;
        end else if (wr_pend_r) begin
            case (wr_addr_r)
                OFS_CODE: prm_r.code <= hwdata;
                OFS_SSPD: prm_r.sspd <= hwdata;
                OFS_TSPD: prm_r.tspd <= hwdata;
                OFS_ACC: prm_r.acc <= hwdata;
                OFS_POS: prm_r.pos <= hwdata;
                OFS_DIV: prm_r.div <= hwdata;
                default: begin
                end
            endcase
        end
    end

    // Control flags are levels; start acts on its rising edge.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_r <= 1'b0;
            soft_trig_r <= 1'b0;
            mon_en_r <= 1'b0;
        end else if (wr_pend_r && wr_addr_r == OFS_CTRL) begin
            start_r <= hwdata[CB_START];
            soft_trig_r <= hwdata[CB_SOFT_TRIG];
            mon_en_r <= hwdata[CB_MON_EN];
        end
    end

    // Start edge and error clear come straight from the write strobe.
    assign start_pulse = wr_pend_r && (wr_addr_r == OFS_CTRL) && hwdata[CB_START] && !start_r;
    assign err_clr_pulse = wr_pend_r && (wr_addr_r == OFS_CTRL) && hwdata[CB_ERR_CLR];

    // The axis engine; more axes would be further instances.
    plt_axis u_axis (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(start_pulse),
        .ext_trig(pin_s2_r[0]),
        .soft_trig(soft_trig_r),
        .lim_plus(pin_s2_r[1]),
        .lim_minus(pin_s2_r[2]),
        .err_clr(err_clr_pulse),
        .prm(prm_r),
        .pulse_out(pulse_out),
        .dir_out(dir_out),
        .busy_r(busy),
        .done_r(done),
        .err_r(err)
    );

    // Home source: bit 4 selects the external switch, else the Z phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            home_in <= 1'b0;
        end else begin
            home_in <= prm_r.code[CC_HOME_LOGIC] ? pin_s2_r[4] : pin_s2_r[3]; // see [RULE_17]
        end
    end

    // Status word, home code decode included.
    always_comb begin
        stat.busy = busy;
        stat.done = done;
        stat.err = err; // see [RULE_20]
        stat.timing_mon = mon_en_r && pin_s2_r[0]; // see [RULE_13]
        stat.home_cfg = (prm_r.code == HOME_MINUS) || (prm_r.code == HOME_PLUS) ||
                        (prm_r.code == HOME_MINUS_INV) || (prm_r.code == HOME_PLUS_INV); // see [RULE_15] [RULE_16]
        stat.home_plus = prm_r.code[CC_DIR_PLUS]; // see [RULE_15]
        stat.home_search = prm_r.code[CC_SEARCH];
    end

    assign addr_ok = hsel && htrans[1] && !hwrite && hready;

    // Read data registered at the address phase, valid in the data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (addr_ok) begin
            case (haddr)
                OFS_CTRL: hrdata <= {29'h0, mon_en_r, soft_trig_r, start_r};
                OFS_CODE: hrdata <= prm_r.code;
                OFS_SSPD: hrdata <= prm_r.sspd;
                OFS_TSPD: hrdata <= prm_r.tspd;
                OFS_ACC: hrdata <= prm_r.acc;
                OFS_POS: hrdata <= prm_r.pos;
                OFS_STAT: hrdata <= {24'h0, stat};
                OFS_DIV: hrdata <= prm_r.div;
                default: hrdata <= '0;
            endcase
        end
    end
endmodule

// ==== logic/plt_pkg.sv ====
// Package for the per-axis pulse limit and trigger controller.
// Assumes a single 125 MHz clock domain and an AHB-Lite register slave.
package plt_pkg;
    // Clock rate in kHz and trigger latency bound in ns.
    localparam int CLK_KHZ = 125000;
    localparam int TRIG_LAT_NS = 15000;
    // Latency bound in cycles, rounded down because it is a longest time.
    localparam int TRIG_LAT_CYC = (TRIG_LAT_NS * (CLK_KHZ / 1000)) / 1000;
    // Parameter ranges.
    localparam logic [31:0] SPEED_MAX = 32'h003d_0900;
    localparam logic [31:0] TGT_MIN = 32'h0000_0001;
    localparam logic [31:0] ACC_MAX = 32'h0000_7fff;
    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CODE = 8'h04;
    localparam logic [7:0] OFS_SSPD = 8'h08;
    localparam logic [7:0] OFS_TSPD = 8'h0c;
    localparam logic [7:0] OFS_ACC = 8'h10;
    localparam logic [7:0] OFS_POS = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h18;
    localparam logic [7:0] OFS_DIV = 8'h1c;
    // Control register bit positions.
    localparam int CB_START = 0;
    localparam int CB_SOFT_TRIG = 1;
    localparam int CB_MON_EN = 2;
    localparam int CB_ERR_CLR = 3;
    // Control code bit positions and home codes.
    localparam int CC_DIR_PLUS = 2;
    localparam int CC_HOME_LOGIC = 4;
    localparam int CC_SEARCH = 6;
    localparam int CC_LIMIT_INV = 7;
    localparam logic [31:0] HOME_MINUS = 32'h2000_0050;
    localparam logic [31:0] HOME_PLUS = 32'h2000_0054;
    localparam logic [31:0] HOME_MINUS_INV = 32'h2000_00d0;
    localparam logic [31:0] HOME_PLUS_INV = 32'h2000_00d4;
    // Default pulse divider 12500: two ticks of 12501 cycles per pulse, near 5 kpps at 125 MHz.
    localparam logic [31:0] DIV_RST = 32'h0000_30d4;
    // Error codes.
    localparam logic [1:0] ERR_NONE = 2'h0;
    localparam logic [1:0] ERR_LIMIT = 2'h1;
    localparam logic [1:0] ERR_VALUE = 2'h2;
    // Axis states.
    typedef enum logic [1:0] {ST_IDLE, ST_JOG, ST_COUNT} plt_state_e;
    // Motion parameters as one carrier.
    typedef struct packed {
        logic [31:0] code;
        logic [31:0] sspd;
        logic [31:0] tspd;
        logic [31:0] acc;
        logic [31:0] pos;
        logic [31:0] div;
    } plt_param_s;
    // Status carrier.
    typedef struct packed {
        logic busy;
        logic done;
        logic [1:0] err;
        logic timing_mon;
        logic home_cfg;
        logic home_plus;
        logic home_search;
    } plt_stat_s;
endpackage

// ==== logic/plt_axis.sv ====
// One axis of the pulse controller: limit checks, trigger and pulse counting.
// Assumes synchronised pin inputs and parameters held stable by software.
`timescale 1ns/100ps
module plt_axis
    import plt_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    input wire logic ext_trig,
    input wire logic soft_trig,
    input wire logic lim_plus,
    input wire logic lim_minus,
    input wire logic err_clr,
    input wire plt_param_s prm,
    output logic pulse_out,
    output logic dir_out,
    output logic busy_r,
    output logic done_r,
    output logic [1:0] err_r
);
    plt_state_e state_r;
    logic [31:0] div_cnt_r;
    logic [31:0] remain_r;
    logic soft_trig_d_r;
    logic lim_p_act;
    logic lim_m_act;
    logic trig;
    logic tick;
    logic bad_val;
    logic cnt_end; // Count used up and the last pulse has ended.

    // Limit polarity: default active when unpowered (low), inverted by code bit.
    assign lim_p_act = prm.code[CC_LIMIT_INV] ? lim_plus : !lim_plus; // see [RULE_03]
    assign lim_m_act = prm.code[CC_LIMIT_INV] ? lim_minus : !lim_minus; // see [RULE_03]
    // Soft trigger fires on its falling edge, so an on then off toggle counts.
    assign trig = ext_trig || (soft_trig_d_r && !soft_trig); // see [RULE_12]
    // Range check of start speed, target speed and acceleration; the position value is always in range.
    assign bad_val = (prm.sspd > SPEED_MAX) || (prm.tspd < TGT_MIN) ||
                     (prm.tspd > SPEED_MAX) || (prm.acc > ACC_MAX); // see [RULE_04] [RULE_05]
    // Half a pulse period elapses when the divider wraps.
    assign tick = (div_cnt_r == '0) && (state_r != ST_IDLE);
    // Counting ends only with the line low, so no half pulse is left behind.
    assign cnt_end = (state_r == ST_COUNT) && (remain_r == '0) && !pulse_out;

    // Remember the soft trigger level for edge detection.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            soft_trig_d_r <= 1'b0;
        end else begin
            soft_trig_d_r <= soft_trig;
        end
    end

    // Pulse rate divider, restarted at every start.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt_r <= '0;
        end else if (state_r == ST_IDLE || div_cnt_r == '0) begin
            div_cnt_r <= prm.div;
        end else begin
            div_cnt_r <= div_cnt_r - 32'h0000_0001;
        end
    end

    // Pulse level toggles each tick; stays low when idle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pulse_out <= 1'b0;
        end else if (state_r == ST_IDLE) begin
            pulse_out <= 1'b0;
        end else if (tick && !cnt_end) begin
            // A tick in the finishing cycle must not start an extra pulse.
            pulse_out <= !pulse_out;
        end
    end

    // Axis sequencer. Each axis owns its own trigger and counter.
    always_ff @(posedge hclk or negedge hresetn) begin // see [RULE_11]
        if (!hresetn) begin
            state_r <= ST_IDLE;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            err_r <= ERR_NONE;
            remain_r <= '0;
            dir_out <= 1'b0;
        end else begin
            if (err_clr) begin
                err_r <= ERR_NONE;
            end
            case (state_r)
                ST_IDLE: begin
                    // Starts are taken only here, so busy blocks new starts.
                    if (start) begin // see [RULE_18]
                        done_r <= 1'b0; // see [RULE_19]
                        if (bad_val) begin
                            err_r <= ERR_VALUE; // see [RULE_04] [RULE_20]
                        end else if (lim_p_act || lim_m_act) begin
                            err_r <= ERR_LIMIT; // see [RULE_01] [RULE_20]
                        end else begin
                            busy_r <= 1'b1;
                            dir_out <= !prm.pos[31];
                            remain_r <= prm.pos[31] ? (~prm.pos + 32'h0000_0001) : prm.pos;
                            // An already active trigger goes straight to counting.
                            state_r <= trig ? ST_COUNT : ST_JOG; // see [RULE_07]
                        end
                    end
                end
                ST_JOG: begin
                    // Runs until triggered or stopped by a limit, even mid-acceleration.
                    if ((dir_out && lim_p_act) || (!dir_out && lim_m_act)) begin // see [RULE_02]
                        err_r <= ERR_LIMIT;
                        busy_r <= 1'b0;
                        state_r <= ST_IDLE;
                    end else if (trig) begin
                        state_r <= ST_COUNT; // see [RULE_08] [RULE_09] [RULE_10]
                    end
                end
                ST_COUNT: begin
                    // Counting begins at the next rising pulse edge, so the latency depends on the divider phase.
                    if ((dir_out && lim_p_act) || (!dir_out && lim_m_act)) begin // see [RULE_02]
                        err_r <= ERR_LIMIT;
                        busy_r <= 1'b0;
                        state_r <= ST_IDLE;
                    end else if (cnt_end) begin
                        busy_r <= 1'b0;
                        done_r <= 1'b1; // see [RULE_19]
                        state_r <= ST_IDLE;
                    end else if (tick && !pulse_out && remain_r != '0) begin
                        // Each rising edge after the trigger is one full pulse counted.
                        remain_r <= remain_r - 32'h0000_0001; // see [RULE_10]
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// ==== dv/plt_field.sv ====
// Field side model: limit switches, timing sensor and home sources.
// Assumes the bench sets the switch states just after a clock edge.
`timescale 1ns/100ps
module plt_field (
    input wire logic absent,
    input wire logic trip_p,
    input wire logic trip_m,
    input wire logic trig,
    input wire logic hz,
    input wire logic hs,
    output logic timing_pin,
    output logic lim_plus_pin,
    output logic lim_minus_pin,
    output logic home_z_pin,
    output logic home_sw_pin
);
    // Closed switches power the pin; a tripped or missing switch leaves it low.
    assign lim_plus_pin = !absent && !trip_p;
    assign lim_minus_pin = !absent && !trip_m;
    // The sensor drives the timing pin high while it sees the target.
    assign timing_pin = trig;
    // Either home source may be wired; the code picks which one counts.
    assign home_z_pin = hz;
    assign home_sw_pin = hs;
endmodule

// ==== dv/plt_top_chk.sv ====
// Checker of the bus answer, limit stops and home selection.
// Assumes it is bound to plt_top and sees only its ports.
`timescale 1ns/100ps
module plt_top_chk
    import plt_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic lim_plus_pin,
    input wire logic lim_minus_pin,
    input wire logic home_z_pin,
    input wire logic home_sw_pin,
    input wire logic pulse_out,
    input wire logic dir_out,
    input wire logic home_in
);
    logic aph; // Address phase taken this edge.
    logic code_wr_r; // Data phase of a code write.
    logic [31:0] code_r; // Shadow of the control code.
    logic lp_act;
    logic lm_act;
    logic hsrc;
    assign aph = hsel && htrans[1] && hready;
    // Limits count as active on a low pin unless the code inverts them.
    assign lp_act = code_r[CC_LIMIT_INV] ? lim_plus_pin : !lim_plus_pin;
    assign lm_act = code_r[CC_LIMIT_INV] ? lim_minus_pin : !lim_minus_pin;
    assign hsrc = code_r[CC_HOME_LOGIC] ? home_sw_pin : home_z_pin;
    // Snoop code writes so polarity is judged as the design judges it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            code_wr_r <= 1'b0;
            code_r <= 32'h0;
        end else begin
            code_wr_r <= aph && hwrite && haddr == OFS_CODE;
            if (code_wr_r) begin
                code_r <= hwdata;
            end
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Six cycles leave room for two sync stages and the stop decision.
    sequence plus_hit; (dir_out && lp_act)[*6]; endsequence
    sequence minus_hit; (!dir_out && lm_act)[*6]; endsequence
    sequence src_steady; $stable(hsrc)[*5]; endsequence
    sequence stat_rd; aph && !hwrite && haddr == OFS_STAT; endsequence
    AST_READY_HIGH: assert property (hreadyout) else $error("hreadyout low");
    AST_RESP_OKAY: assert property (!hresp) else $error("hresp not okay");
    AST_RST_QUIET: assert property ($rose(hresetn) |-> !pulse_out ##1 !pulse_out) else $error("pulse after reset");
    AST_LIM_PLUS: assert property (plus_hit |-> !$rose(pulse_out)) else $error("pulse on plus limit");
    AST_LIM_MINUS: assert property (minus_hit |-> !$rose(pulse_out)) else $error("pulse on minus limit");
    AST_HOME_SRC: assert property (src_steady |-> home_in == hsrc) else $error("home source wrong");
    AST_UNMAP: assert property (aph && !hwrite && haddr >= 8'h20 |=> hrdata == 32'h0) else $error("unmapped data");
    AST_ERR_IDLE: assert property (stat_rd |=> !(hrdata[7] && hrdata[5:4] != ERR_NONE)) else $error("busy with error");
endmodule
bind plt_top plt_top_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata,
    .hreadyout, .hresp, .lim_plus_pin, .lim_minus_pin, .home_z_pin, .home_sw_pin, .pulse_out, .dir_out, .home_in);

// ==== dv/plt_top_tb.sv ====
// Self-checking bench: AHB-Lite master tasks and one task per scenario.
// Assumes plt_top answers with zero wait states but never relies on it.
`timescale 1ns/100ps
module plt_top_tb;
    import plt_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, q;
    logic absent = 1'b0, trip_p = 1'b0, trip_m = 1'b0, trig = 1'b0, hz = 1'b0, hs = 1'b0;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, pulse_out, dir_out, home_in, tpin, lpp, lmp, hzp, hsp;
    int num_errors = 0, n_compared = 0, n_pulse = 0, n0;
    plt_field fld (.absent, .trip_p, .trip_m, .trig, .hz, .hs, .timing_pin(tpin), .lim_plus_pin(lpp),
        .lim_minus_pin(lmp), .home_z_pin(hzp), .home_sw_pin(hsp));
    plt_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata,
        .hrdata, .hreadyout, .hresp, .timing_pin(tpin), .lim_plus_pin(lpp), .lim_minus_pin(lmp),
        .home_z_pin(hzp), .home_sw_pin(hsp), .pulse_out, .dir_out, .home_in);
    initial begin
        forever #4 hclk = ~hclk;
    end
    // Every rising edge of the pulse train is one pulse to the driver.
    always @(posedge pulse_out) begin
        n_pulse++;
    end
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // Waits for hready at a rising edge; a hung slave ends the run.
    task automatic rdy();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 64);
        if (k >= 64) begin
            num_errors++;
            give_verdict();
        end
    endtask
    // One single word transfer; read data lands in q.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        q = hrdata;
    endtask
    task automatic stat();
        xfer(1'b0, OFS_STAT, 32'h0);
    endtask
    task automatic wait_bit(input int b, input logic v);
        int k;
        k = 0;
        do begin
            stat();
            k++;
        end while (q[b] !== v && k < 2000);
        if (k >= 2000) begin
            num_errors++;
            give_verdict();
        end
    endtask
    // Parameters are written in one burst just before a start; the absent limit start reuses earlier ones, the busy start rewrites only the position.
    task automatic prm(input logic [31:0] c, s, t, a, p);
        xfer(1'b1, OFS_CODE, c);
        xfer(1'b1, OFS_SSPD, s);
        xfer(1'b1, OFS_TSPD, t);
        xfer(1'b1, OFS_ACC, a);
        xfer(1'b1, OFS_POS, p);
    endtask
    // The start bit acts on its rising edge, so it is lowered first.
    task automatic go();
        xfer(1'b1, OFS_CTRL, 32'h0);
        xfer(1'b1, OFS_CTRL, 32'h1);
    endtask
    task automatic clr();
        xfer(1'b1, OFS_CTRL, 32'h8);
    endtask
    task automatic t_reset();
        xfer(1'b0, OFS_DIV, 32'h0);
        chk("div", DIV_RST, q);
        stat();
        chk("status", 32'h0, q);
        xfer(1'b1, 8'h40, 32'hffff_ffff);
        xfer(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, q);
        xfer(1'b1, OFS_DIV, 32'h10);
        $display("test reset done");
    endtask
    task automatic t_value();
        logic [31:0] sv [4] = '{SPEED_MAX + 32'h1, 32'h1f4, 32'h1f4, 32'h0};
        logic [31:0] tv [4] = '{32'h2710, 32'h0, 32'h2710, SPEED_MAX};
        logic [31:0] av [4] = '{32'h0, 32'h0, ACC_MAX + 32'h1, ACC_MAX};
        for (int i = 0; i < 4; i++) begin
            prm(32'h0, sv[i], tv[i], av[i], 32'h5);
            n0 = n_pulse;
            go();
            stat();
            chk("edge busy", 32'(i == 3), 32'(q[7]));
            trip_p <= 1'b1;
            cyc(20);
            stat();
            chk("err", i == 3 ? 32'(ERR_LIMIT) : 32'(ERR_VALUE), 32'(q[5:4]));
            chk("busy", 32'h0, 32'(q[7]));
            trip_p <= 1'b0;
            clr();
        end
        $display("test value done");
    endtask
    task automatic t_trig();
        trip_m <= 1'b1;
        prm(32'h0, 32'h1f4, 32'h2710, 32'h0, 32'h5);
        go();
        stat();
        chk("start limit", 32'(ERR_LIMIT), 32'(q[5:4]));
        clr();
        trip_m <= 1'b0;
        absent <= 1'b1;
        go();
        stat();
        chk("absent limit", 32'(ERR_LIMIT), 32'(q[5:4]));
        clr();
        trig <= 1'b1;
        prm(32'h80, 32'h1f4, 32'h2710, 32'h0, 32'h5);
        n0 = n_pulse;
        go();
        wait_bit(6, 1'b1);
        chk("pulses", 32'h5, 32'(n_pulse - n0));
        chk("dir", 32'h1, 32'(dir_out));
        cyc(100);
        stat();
        chk("done held", 32'h1, 32'(q[6]));
        absent <= 1'b0;
        trig <= 1'b0;
        $display("test trigger done");
    endtask
    task automatic t_jog();
        prm(32'h0, 32'h1f4, 32'h2710, 32'h0, 32'h4);
        go();
        stat();
        chk("done clear", 32'h0, 32'(q[6]));
        n0 = n_pulse;
        cyc(400);
        stat();
        chk("jog runs", 32'h1, 32'(q[7] && n_pulse > n0 + 2));
        // A start while busy must be ignored; a restart would load the larger count.
        xfer(1'b1, OFS_POS, 32'h10);
        go();
        stat();
        chk("busy start", 32'h1, 32'(q[7] && q[5:4] == ERR_NONE));
        xfer(1'b1, OFS_CTRL, 32'h3);
        xfer(1'b1, OFS_CTRL, 32'h1);
        n0 = n_pulse;
        wait_bit(6, 1'b1);
        chk("counted", 32'h1, 32'(n_pulse - n0 inside {[4:5]}));
        prm(32'h0, 32'h1f4, 32'h2710, 32'h0, 32'hffff_fffc);
        go();
        cyc(100);
        trip_m <= 1'b1;
        cyc(20);
        stat();
        chk("rev stop", 32'(ERR_LIMIT), 32'(q[5:4]));
        n0 = n_pulse;
        cyc(100);
        chk("stopped", 32'(n0), 32'(n_pulse));
        trip_m <= 1'b0;
        clr();
        $display("test jog done");
    endtask
    task automatic t_mon_home();
        logic [31:0] hc [5] = '{HOME_MINUS, HOME_PLUS, HOME_MINUS_INV, HOME_PLUS_INV, 32'h0};
        xfer(1'b1, OFS_CTRL, 32'h4);
        trig <= 1'b1;
        cyc(5);
        stat();
        chk("mon on", 32'h1, 32'(q[3]));
        trig <= 1'b0;
        cyc(5);
        stat();
        chk("mon off", 32'h0, 32'(q[3]));
        hs <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, OFS_CODE, hc[i]);
            cyc(6);
            stat();
            chk("home cfg", {29'h0, i < 4, hc[i][2], hc[i][6]}, {29'h0, q[2:0]});
            chk("home in", 32'(hc[i][4]), 32'(home_in));
        end
        $display("test monitor home done");
    endtask
    initial begin
        cyc(20);
        hresetn <= 1'b1;
        cyc(1);
        t_reset();
        t_value();
        t_trig();
        t_jog();
        t_mon_home();
        give_verdict();
    end
endmodule
